// ### cmd_sort.sv
// Command sorting and active bus selection for a dual-bus monitor terminal
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps

// How it works
// - Transmit RT-RT codes only for valid commands
// - Control bits 4-5 pick active bus
// - Idle select bits take the bus of the first accepted command
// - New command pulses its bus indication
// - Inactive bus command leaves active message alone
// - Select toggle abandons unfinished active message
// - Switching command gets no response
// - Later commands on new bus fully processed
// - Unmatched commands captured on inactive bus
// - Mode bits 3:2 at 00 enable address
// - Respond when address and parity pins match
// - Indication identical for valid and monitored
module cmd_sort
    import cmd_sort_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Decoded commands and message completion
    input  wire cmd_s        cmd,
    input  wire logic        msg_done,
    // Terminal address pins
    input  wire logic [4:0]  terminal_address_pins,
    input  wire logic        terminal_address_parity_pin,
    // Host register port
    input  wire reg_req_s    req,
    output logic [15:0]      rdata,
    // Command indications
    output logic             bus_a_command_seen,
    output logic             bus_b_command_seen,
    // Engine control
    output logic             respond,
    output logic             respond_bus,
    output logic             abandon,
    output logic             abandon_bus,
    // Interrupt
    output logic             irq
);

    logic [5:0]          pin_s1_q;
    logic [5:0]          pin_s2_q;
    logic [5:0]          pin_s3_q;
    logic [5:0]          pin_q;
    logic [15:0]         ctrl_q;
    logic [15:0]         cmd1_q;
    logic [15:0]         cmd2_q;
    logic [15:0]         msg_type_q;
    logic [IRQ_BITS-1:0] stat_q;
    logic [IRQ_BITS-1:0] mask_q;
    logic [IRQ_BITS-1:0] stat_set;
    logic                busy_q;
    logic                busy_bus_q;
    logic                addr_ok;
    logic                match1;
    logic                match2;
    logic                bcast1;
    logic                addr_mode;
    logic                active_bus;
    logic                on_active;
    logic                ctrl_wr;
    logic [1:0]          new_sel;
    logic                switch_ev;
    logic                accept;
    logic                do_respond;
    logic [15:0]         msg_type_d;
    logic [15:0]         rdata_d;
    logic [IRQ_BITS-1:0] stat_d;
    logic [4:0]          addr1;
    logic [4:0]          addr2;
    logic [1:0]          cur_sel;
    logic                tx_cmd2;
    logic                is_mode;
    logic                cmd_on_a;
    logic                cmd_on_b;
    logic                mask_wr;
    logic                stat_rd;
    logic                abort_ev;

    // Address pins cross in from outside; a change counts once stages two and three agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
            pin_s3_q <= 6'h00;
            pin_q    <= 6'h00;
        end else begin
            pin_s1_q <= {terminal_address_parity_pin, terminal_address_pins};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) begin
                pin_q <= pin_s3_q;
            end
        end
    end

    // odd parity over the five address pins and the parity pin
    assign addr_ok   = ^pin_q;
    assign addr_mode = (ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_MT_ADDR);
    assign addr1     = cmd.word1[ADDR_HI:ADDR_LO];
    assign addr2     = cmd.word2[ADDR_HI:ADDR_LO];
    // Only the transmit half of a pair can make this terminal the talker
    assign tx_cmd2   = cmd.pair && cmd.word2[TR_BIT];
    assign match1    = addr_mode && addr_ok && (addr1 == pin_q[4:0]);
    assign match2    = addr_mode && addr_ok && tx_cmd2 && (addr2 == pin_q[4:0]);
    assign bcast1    = (addr1 == ADDR_BCAST);
    // Mode codes use a subaddress of all zeros or all ones
    assign is_mode   = (cmd.word1[SUB_HI:SUB_LO] == SUB_MC0) || (cmd.word1[SUB_HI:SUB_LO] == SUB_MC1);

    assign cur_sel    = ctrl_q[CTRL_SEL_B:CTRL_SEL_A];
    assign active_bus = ctrl_q[CTRL_SEL_B] && !ctrl_q[CTRL_SEL_A];
    // With no select bit set the first command claims its own bus
    assign on_active  = (cur_sel == 2'h0) || (cmd.bus == active_bus);
    assign cmd_on_a   = cmd.valid && (cmd.bus == BUS_A);
    assign cmd_on_b   = cmd.valid && (cmd.bus == BUS_B);

    assign ctrl_wr   = req.wr && (req.addr == REG_CTRL);
    assign mask_wr   = req.wr && (req.addr == REG_IRQ_MASK);
    assign stat_rd   = req.rd && (req.addr == REG_IRQ_STAT);
    assign new_sel   = req.wdata[CTRL_SEL_B:CTRL_SEL_A];
    assign switch_ev = ctrl_wr && (new_sel != cur_sel);
    // Only a message still running has anything to abandon
    assign abort_ev  = switch_ev && busy_q;

    // only active bus commands enter the engine
    // A switch beats a command in the same cycle, so the new bus starts from a clean engine
    assign accept     = cmd.valid && on_active && !switch_ev;
    // inactive bus commands are never answered, even after a switch
    // A broadcast first word needs no reply, but the talker of a broadcast pair still answers
    assign do_respond = accept && ((match1 && !bcast1) || match2);

    // Message type decode
    always_comb begin
        msg_type_d = MT_RX_BC;
        if (cmd.pair) begin
            // transmit codes only for a valid transmit half
            if (match2) begin
                msg_type_d = bcast1 ? MT_RTRT_TX_B : MT_RTRT_TX;
            end else begin
                msg_type_d = bcast1 ? MT_RTRT_BC : MT_RTRT;
            end
        end else if (is_mode) begin
            unique case ({cmd.word1[TR_BIT], cmd.word1[MDAT_BIT]})
                2'b10, 2'b00: msg_type_d = bcast1 ? MT_MC_BCAST : MT_MC_NODAT;
                2'b11:        msg_type_d = bcast1 ? MT_MC_BCAST : MT_MC_TXDAT;
                2'b01:        msg_type_d = bcast1 ? MT_MC_RXDAT_B : MT_MC_RXDAT;
            endcase
        end else if (cmd.word1[TR_BIT]) begin
            msg_type_d = bcast1 ? MT_MC_BCAST : MT_TX;
        end else begin
            msg_type_d = bcast1 ? MT_RX_BC_BC : MT_RX_BC;
        end
    end

    // every command is captured whatever its bus
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd1_q     <= 16'h0000;
            cmd2_q     <= 16'h0000;
            msg_type_q <= 16'h0000;
        end else if (cmd.valid) begin
            cmd1_q     <= cmd.word1;
            msg_type_q <= msg_type_d;
            if (cmd.pair) begin
                cmd2_q <= cmd.word2;
            end
        end
    end

    // Control register; a host write wins over the idle bus update
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= req.wdata & CTRL_WMASK;
        end else if (accept && (ctrl_q[CTRL_SEL_B:CTRL_SEL_A] == 2'h0)) begin
            ctrl_q[CTRL_SEL_A] <= (cmd.bus == BUS_A);
            ctrl_q[CTRL_SEL_B] <= (cmd.bus == BUS_B);
        end
    end

    // Message in progress on the active bus
    // Inactive bus commands never reach here, so the running message carries on
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            busy_bus_q <= BUS_A;
        end else if (switch_ev) begin
            busy_q <= 1'b0;
        end else if (accept) begin
            busy_q     <= 1'b1;
            busy_bus_q <= cmd.bus;
        end else if (msg_done) begin
            busy_q <= 1'b0;
        end
    end

    // Engine pulses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            respond     <= 1'b0;
            respond_bus <= BUS_A;
            abandon     <= 1'b0;
            abandon_bus <= BUS_A;
        end else begin
            respond <= do_respond;
            if (do_respond) begin
                respond_bus <= cmd.bus;
            end
            abandon <= abort_ev;
            if (abort_ev) begin
                abandon_bus <= busy_bus_q;
            end
        end
    end

    // per-bus indication; same for valid and monitored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_a_command_seen <= 1'b0;
            bus_b_command_seen <= 1'b0;
        end else begin
            bus_a_command_seen <= cmd_on_a;
            bus_b_command_seen <= cmd_on_b;
        end
    end

    assign stat_set[IRQ_CMD_A]   = cmd_on_a;
    assign stat_set[IRQ_CMD_B]   = cmd_on_b;
    assign stat_set[IRQ_ABORT]   = abort_ev;
    assign stat_set[IRQ_RESPOND] = do_respond;
    // Reading clears the flags, but an event landing in the read cycle survives
    assign stat_d = stat_rd ? stat_set : (stat_q | stat_set);

    // Sticky status, cleared by reading it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= '0;
        end else if (mask_wr) begin
            mask_q <= req.wdata[IRQ_BITS-1:0];
        end
    end

    // Registered from the next status so the pin never glitches on combinational decode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_d & mask_q);
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rdata_d = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                REG_CMD1:     rdata_d = cmd1_q;
                REG_CMD2:     rdata_d = cmd2_q;
                REG_CTRL:     rdata_d = ctrl_q;
                REG_MSG_TYPE: rdata_d = msg_type_q;
                REG_IRQ_STAT: rdata_d = {{(16-IRQ_BITS){1'b0}}, stat_q};
                REG_IRQ_MASK: rdata_d = {{(16-IRQ_BITS){1'b0}}, mask_q};
                default:      rdata_d = 16'h0000;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_d;
        end
    end

endmodule // cmd_sort

// ### cmd_sort_pkg.sv
// Shared constants and types for the monitor command sorting block
package cmd_sort_pkg;

    // Register indices on the host port
    localparam logic [2:0] REG_CMD1      = 3'h0;
    localparam logic [2:0] REG_CMD2      = 3'h1;
    localparam logic [2:0] REG_CTRL      = 3'h2;
    localparam logic [2:0] REG_MSG_TYPE  = 3'h3;
    localparam logic [2:0] REG_IRQ_STAT  = 3'h4;
    localparam logic [2:0] REG_IRQ_MASK  = 3'h5;

    // Control register fields
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_MODE_HI = 3;
    localparam int CTRL_SEL_A   = 4;
    localparam int CTRL_SEL_B   = 5;
    localparam logic [1:0]  MODE_MT_ADDR = 2'h0;
    localparam logic [15:0] CTRL_RESET   = 16'h0010;
    localparam logic [15:0] CTRL_WMASK   = 16'h003c;

    // Interrupt status fields
    localparam int IRQ_CMD_A   = 0;
    localparam int IRQ_CMD_B   = 1;
    localparam int IRQ_ABORT   = 2;
    localparam int IRQ_RESPOND = 3;
    localparam int IRQ_BITS    = 4;

    // Command word fields
    localparam int  ADDR_HI = 15;
    localparam int  ADDR_LO = 11;
    localparam int  TR_BIT  = 10;
    localparam int  SUB_HI  = 9;
    localparam int  SUB_LO  = 5;
    localparam int  MDAT_BIT = 4;
    localparam logic [4:0] ADDR_BCAST = 5'h1f;
    localparam logic [4:0] SUB_MC0    = 5'h00;
    localparam logic [4:0] SUB_MC1    = 5'h1f;

    // Message type codes
    localparam logic [15:0] MT_RX_BC      = 16'h0001;
    localparam logic [15:0] MT_RX_BC_BC   = 16'h0080;
    localparam logic [15:0] MT_RTRT       = 16'h0004;
    localparam logic [15:0] MT_RTRT_BC    = 16'h0100;
    localparam logic [15:0] MT_TX         = 16'h0402;
    localparam logic [15:0] MT_MC_NODAT   = 16'h0410;
    localparam logic [15:0] MT_MC_BCAST   = 16'h0400;
    localparam logic [15:0] MT_MC_TXDAT   = 16'h2420;
    localparam logic [15:0] MT_MC_RXDAT   = 16'h0040;
    localparam logic [15:0] MT_MC_RXDAT_B = 16'h0800;
    localparam logic [15:0] MT_RTRT_TX    = 16'h1008;
    localparam logic [15:0] MT_RTRT_TX_B  = 16'h0200;

    // Bus identifiers
    localparam logic BUS_A = 1'b0;
    localparam logic BUS_B = 1'b1;

    // One decoded command from the bus decoders
    typedef struct packed {
        logic        valid;
        logic        bus;
        logic        pair;
        logic [15:0] word1;
        logic [15:0] word2;
    } cmd_s;

    // Host register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;

endpackage

// ### cmd_sort_checker.sv
// Port assertions for the command sorting block
`timescale 1ns/10ps
module cmd_sort_checker
    import cmd_sort_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Stimulus side
    input wire cmd_s        cmd,
    input wire logic [4:0]  terminal_address_pins,
    input wire reg_req_s    req,
    // Outputs
    input wire logic        bus_a_command_seen,
    input wire logic        bus_b_command_seen,
    input wire logic        respond,
    input wire logic        respond_bus,
    input wire logic        abandon
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    bus_a_seen_a: assert property (cmd.valid && cmd.bus == BUS_A |=> bus_a_command_seen)
        else $error("bus A command not indicated");
    bus_b_seen_a: assert property (cmd.valid && cmd.bus == BUS_B |=> bus_b_command_seen)
        else $error("bus B command not indicated");
    seen_cause_a: assert property (bus_a_command_seen || bus_b_command_seen |-> $past(cmd.valid))
        else $error("indication without command");
    one_bus_a: assert property (!(bus_a_command_seen && bus_b_command_seen))
        else $error("both buses indicated");
    respond_bus_a: assert property (respond |-> $past(cmd.valid) && respond_bus == $past(cmd.bus))
        else $error("respond on wrong bus");
    respond_addr_a: assert property (respond |-> $past(
        (cmd.word1[ADDR_HI:ADDR_LO] == terminal_address_pins && cmd.word1[ADDR_HI:ADDR_LO] != ADDR_BCAST)
        || (cmd.pair && cmd.word2[ADDR_HI:ADDR_LO] == terminal_address_pins)))
        else $error("respond without address match");
    abandon_cause_a: assert property (abandon |-> $past(req.wr && req.addr == REG_CTRL))
        else $error("abandon without control write");
    abandon_pulse_a: assert property (abandon |=> !abandon)
        else $error("abandon longer than one cycle");

    cover property (respond);
    cover property (abandon);
    cover property (bus_b_command_seen && !respond);
endmodule // cmd_sort_checker

bind cmd_sort cmd_sort_checker u_chk (
    .clock(clock), .rst_n(rst_n), .cmd(cmd), .terminal_address_pins(terminal_address_pins),
    .req(req), .bus_a_command_seen(bus_a_command_seen), .bus_b_command_seen(bus_b_command_seen),
    .respond(respond), .respond_bus(respond_bus), .abandon(abandon));

// ### cmd_src.sv
// Bus decoder model feeding decoded commands
`timescale 1ns/10ps
module cmd_src
    import cmd_sort_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Bench requests
    input  wire logic send,
    input  wire logic fin,
    input  wire cmd_s nxt,
    // Decoder outputs
    output cmd_s      cmd,
    output logic      msg_done
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd      <= '0;
            msg_done <= 1'b0;
        end else begin
            // Idle words flip so a stale word never passes for a fresh one
            cmd      <= send ? nxt : {1'b0, cmd.bus, cmd.pair, ~cmd.word1, ~cmd.word2};
            msg_done <= fin;
        end
    end
endmodule // cmd_src

// ### cmd_sort_bench.sv
// Self-checking bench for the command sorting block
`timescale 1ns/10ps
module cmd_sort_bench;
    import cmd_sort_pkg::*;
    localparam logic [4:0] TA = 5'h0b;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        send = 1'b0;
    logic        fin = 1'b0;
    logic        rd_seen = 1'b0;
    logic        par = 1'b0;
    logic [1:0]  ce;
    cmd_s        nxt = '0;
    reg_req_s    req = '0;
    cmd_s        cmd;
    logic        msg_done;
    logic [15:0] rdata;
    logic        seen_a, seen_b, rsp, rsp_bus, abn, abn_bus, irq;
    logic [15:0] rq[$];
    logic [1:0]  cq[$];
    logic        aq[$];
    int          seed = 32'h623e;
    int          bad_count = 0;
    int          checks_done = 0;

    always #20 clock = ~clock;

    cmd_src u_src (.clock(clock), .rst_n(rst_n), .send(send), .fin(fin), .nxt(nxt), .cmd(cmd),
        .msg_done(msg_done));
    cmd_sort DUT (.clock(clock), .rst_n(rst_n), .cmd(cmd), .msg_done(msg_done),
        .terminal_address_pins(TA), .terminal_address_parity_pin(par), .req(req), .rdata(rdata),
        .bus_a_command_seen(seen_a), .bus_b_command_seen(seen_b), .respond(rsp),
        .respond_bus(rsp_bus), .abandon(abn), .abandon_bus(abn_bus), .irq(irq));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (e !== s) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_sim;
        $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Oldest note against each result as it shows
    always @(posedge clock) rd_seen <= req.rd;
    always @(negedge clock) begin
        if (rd_seen)
            chk("rdata", rq.size() ? rq.pop_front() : 'x, rdata);
        if (seen_a | seen_b) begin
            ce = cq.size() ? cq.pop_front() : 2'bxx;
            chk("seen", ce, {seen_b, rsp});
            if (ce[0])
                chk("respond_bus", ce[1], rsp_bus);
        end
        if (abn)
            chk("abandon_bus", aq.size() ? aq.pop_front() : 'x, abn_bus);
    end

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        req <= '0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clock);
        req <= '{1'b0, 1'b1, a, 16'h0};
        rq.push_back(e);
        @(posedge clock);
        req <= '0;
    endtask

    task automatic snd(input logic b, input logic p, input logic [15:0] w1, input logic [15:0] w2, input logic r);
        @(posedge clock);
        nxt <= '{1'b1, b, p, w1, w2};
        send <= 1'b1;
        cq.push_back({b, r});
        @(posedge clock);
        send <= 1'b0;
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("irq", e, irq);
    endtask

    // Random count field keeps subaddress legal
    function automatic logic [15:0] cw(input logic [4:0] a, input logic t);
        logic [31:0] r;
        r = $random(seed);
        cw = {a, t, 5'h01, r[4:0]};
    endfunction

    initial begin
        repeat (4000) @(posedge clock);
        bad_count++;
        end_sim();
    end

    initial begin
        logic [15:0] w;
        logic [15:0] v;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        rd(REG_CTRL, 16'h0010);
        rd(3'h7, 16'h0);
        rd(REG_IRQ_STAT, 16'h0);
        $display("Test reset done");
        w = cw(TA, 1'b0);
        snd(BUS_A, 1'b0, w, 16'h0, 1'b1);
        rd(REG_CMD1, w);
        rd(REG_MSG_TYPE, MT_RX_BC);
        snd(BUS_A, 1'b0, cw(ADDR_BCAST, 1'b0), 16'h0, 1'b0);
        rd(REG_MSG_TYPE, MT_RX_BC_BC);
        v = cw(5'h03, 1'b0);
        w = cw(TA, 1'b1);
        snd(BUS_A, 1'b1, v, w, 1'b1);
        rd(REG_MSG_TYPE, MT_RTRT_TX);
        rd(REG_CMD2, w);
        snd(BUS_A, 1'b1, v, cw(5'h04, 1'b1), 1'b0);
        rd(REG_MSG_TYPE, MT_RTRT);
        snd(BUS_A, 1'b1, cw(ADDR_BCAST, 1'b0), cw(TA, 1'b1), 1'b1);
        rd(REG_MSG_TYPE, MT_RTRT_TX_B);
        snd(BUS_A, 1'b1, cw(ADDR_BCAST, 1'b0), cw(5'h04, 1'b1), 1'b0);
        rd(REG_MSG_TYPE, MT_RTRT_BC);
        snd(BUS_A, 1'b0, {TA, 1'b1, SUB_MC0, 5'h12}, 16'h0, 1'b1);
        rd(REG_MSG_TYPE, MT_MC_TXDAT);
        $display("Test active bus done");
        @(posedge clock) fin <= 1'b1;
        @(posedge clock) fin <= 1'b0;
        wr(REG_CTRL, 16'h0020);
        wr(REG_CTRL, 16'h0010);
        snd(BUS_A, 1'b0, cw(TA, 1'b0), 16'h0, 1'b1);
        snd(BUS_B, 1'b0, cw(TA, 1'b0), 16'h0, 1'b0);
        aq.push_back(BUS_A);
        wr(REG_CTRL, 16'h0020);
        rd(REG_CTRL, 16'h0020);
        snd(BUS_B, 1'b0, cw(TA, 1'b1), 16'h0, 1'b1);
        w = cw(5'h05, 1'b0);
        snd(BUS_A, 1'b0, w, 16'h0, 1'b0);
        rd(REG_CMD1, w);
        @(posedge clock) par <= 1'b1;
        repeat (5) @(posedge clock);
        snd(BUS_B, 1'b0, cw(TA, 1'b0), 16'h0, 1'b0);
        $display("Test bus switch done");
        rd(REG_IRQ_STAT, 16'h000f);
        wr(REG_IRQ_MASK, 16'h0002);
        wr(REG_CTRL, 16'hffe4);
        rd(REG_CTRL, 16'h0024);
        snd(BUS_A, 1'b0, cw(TA, 1'b0), 16'h0, 1'b0);
        irq_is(1'b0);
        snd(BUS_B, 1'b0, cw(TA, 1'b0), 16'h0, 1'b0);
        irq_is(1'b1);
        rd(REG_IRQ_STAT, 16'h0003);
        irq_is(1'b0);
        chk("queues", 16'h0, 16'(rq.size() + cq.size() + aq.size()));
        $display("Test monitor mode done");
        end_sim();
    end
endmodule // cmd_sort_bench
